// ==== design/pb_bpart_mode_decoder.sv ====
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "pb_mode_cfg.svh"

// Operation
// - three B-part modes chosen by codeword
// - bidirectional uses previous and current P-parts
// - bidirectional vectors scaled with zero delta
// - bidirectional forces P-part vector data parsing
// - forward: previous reference, one 16x16 vector
// - forward vector data is standalone, not refinement
// - predictor is left forward vector or zero
// - same VLC difference, added to predictor
// - unrestricted vectors also for B-part vectors
// - backward: reconstructed P-part, no vectors
// - code 0 bidir; 10 bidir plus pattern
// - 110 forward vector; 1110 pattern plus vector
// - 11110 backward; 11111 backward plus pattern
// - active only when picture type signals it
module pb_bpart_mode_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`DATA_W-1:0] pwdata,
  output logic [`DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extended_picture_type,
  input wire pb_mode_pkg::mb_ctx_s mb_ctx,
  input wire logic code_bit_valid,
  input wire logic code_bit,
  output logic code_bit_ready,
  input wire pb_mode_pkg::vec_data_s motion_vector_data,
  output logic vec_data_ready,
  output pb_mode_pkg::mode_report_s mode_report,
  output pb_mode_pkg::mc_cmd_s mc_cmd
);
  import pb_mode_pkg::*;

  typedef struct packed {
    dec_state_e state;
    logic enable;
    logic unrestricted;
    logic [`TR_W-1:0] trb;
    logic [`TR_W-1:0] trd;
    logic [`ONES_W-1:0] ones;
    logic left_edge;
    logic p_intra;
    vec_s p_vec;
    bpart_mode_e mode;
    logic cbp;
    logic fwd_present;
    vec_s left_vec;
    logic left_has;
    logic orphan;
    logic [`CNT_W-1:0] mb_count;
    mode_report_s report;
    mc_cmd_s cmd;
    logic pready;
    logic pslverr;
    logic [`DATA_W-1:0] prdata;
  } st_s;

  st_s st;
  st_s next_st;
  vec_s scaled_fwd;
  vec_s scaled_bwd;

  // narrow range wraps to 6 bits; unrestricted keeps the full width
  function automatic vec_comp_t wrap_comp(input logic signed [`VEC_W:0] sum,
                                          input logic unres);
    begin
      if (unres) begin
        wrap_comp = sum[`VEC_W-1:0];
      end else begin
        wrap_comp = {{(`VEC_W-`VEC_NARROW_W){sum[`VEC_NARROW_W-1]}},
                     sum[`VEC_NARROW_W-1:0]};
      end
    end
  endfunction : wrap_comp

  function automatic logic signed [`VEC_W:0] add_comp(input vec_comp_t a,
                                                      input vec_comp_t b);
    begin
      add_comp = $signed({a[`VEC_W-1], a}) + $signed({b[`VEC_W-1], b});
    end
  endfunction : add_comp

  pb_vector_scaler u_scaler (
    .p_vec(st.p_vec),
    .trb(st.trb),
    .trd(st.trd),
    .fwd(scaled_fwd),
    .bwd(scaled_bwd)
  );

  always_comb begin
    logic active;
    logic [`ONES_W-1:0] idx;
    vec_s pred;
    vec_s fwd_vec;
    logic [`DATA_W-1:0] rd;
    active = 1'b0;
    idx = '0;
    pred = '0;
    fwd_vec = '0;
    rd = '0;
    next_st = st;
    next_st.report.valid = 1'b0;
    next_st.cmd.valid = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // legacy PB macroblocks belong to another decoder
    active = st.enable & extended_picture_type;

    case (st.state)
      ST_IDLE: begin
        if (mb_ctx.start && active) begin
          next_st.left_edge = mb_ctx.left_edge;
          next_st.p_intra = mb_ctx.p_intra;
          next_st.p_vec = mb_ctx.p_vec;
          next_st.ones = '0;
          next_st.state = ST_CODE;
        end
      end
      ST_CODE: begin
        if (code_bit_valid) begin
          // a zero ends the code; the fifth bit ends it either way
          if (!code_bit || st.ones == `ONES_LAST) begin
            idx = code_bit ? `CODE_IDX_LAST : st.ones;
            case (idx)
              3'h0: begin
                next_st.mode = MODE_BIDIR;
                next_st.cbp = 1'b0;
                next_st.fwd_present = 1'b0;
              end
              3'h1: begin
                next_st.mode = MODE_BIDIR;
                next_st.cbp = 1'b1;
                next_st.fwd_present = 1'b0;
              end
              3'h2: begin
                next_st.mode = MODE_FWD;
                next_st.cbp = 1'b0;
                next_st.fwd_present = 1'b1;
              end
              3'h3: begin
                next_st.mode = MODE_FWD;
                next_st.cbp = 1'b1;
                next_st.fwd_present = 1'b1;
              end
              3'h4: begin
                next_st.mode = MODE_BWD;
                next_st.cbp = 1'b0;
                next_st.fwd_present = 1'b0;
              end
              default: begin
                next_st.mode = MODE_BWD;
                next_st.cbp = 1'b1;
                next_st.fwd_present = 1'b0;
              end
            endcase
            next_st.report.valid = 1'b1;
            next_st.report.mode = next_st.mode;
            next_st.report.block_pattern_present = next_st.cbp;
            next_st.report.forward_vector_present = next_st.fwd_present;
            // P-part vectors even for an intra P-part when bidirectional
            next_st.report.p_vec_data_required = (next_st.mode == MODE_BIDIR) ||
                                                 !st.p_intra;
            next_st.state = next_st.fwd_present ? ST_VEC : ST_ISSUE;
          end else begin
            next_st.ones = st.ones + `ONES_W'(1);
          end
        end
      end
      ST_VEC: begin
        if (motion_vector_data.valid) begin
          // slice starts count as left edges, flagged by the parser
          if (!st.left_edge && st.left_has) begin
            pred = st.left_vec;
          end
          // the field is a vector of its own, never added to scaled ones
          fwd_vec.x = wrap_comp(add_comp(pred.x, motion_vector_data.diff.x),
                                st.unrestricted);
          fwd_vec.y = wrap_comp(add_comp(pred.y, motion_vector_data.diff.y),
                                st.unrestricted);
          next_st.cmd.valid = 1'b1;
          next_st.cmd.mode = MODE_FWD;
          next_st.cmd.use_prev_ref = 1'b1;
          next_st.cmd.use_cur_p = 1'b0;
          next_st.cmd.unrestricted = st.unrestricted;
          next_st.cmd.fwd = fwd_vec;
          next_st.cmd.bwd = '0;
          next_st.left_vec = fwd_vec;
          next_st.left_has = 1'b1;
          next_st.mb_count = st.mb_count + `CNT_W'(1);
          next_st.state = ST_IDLE;
        end
      end
      ST_ISSUE: begin
        next_st.cmd.valid = 1'b1;
        next_st.cmd.mode = st.mode;
        next_st.cmd.unrestricted = st.unrestricted;
        if (st.mode == MODE_BIDIR) begin
          next_st.cmd.use_prev_ref = 1'b1;
          next_st.cmd.use_cur_p = 1'b1;
          next_st.cmd.fwd = scaled_fwd;
          next_st.cmd.bwd = scaled_bwd;
        end else begin
          // reconstructed P-part taken as is, vectors zero
          next_st.cmd.use_prev_ref = 1'b0;
          next_st.cmd.use_cur_p = 1'b1;
          next_st.cmd.fwd = '0;
          next_st.cmd.bwd = '0;
        end
        // no forward vector here, so the right neighbour predicts zero
        next_st.left_has = 1'b0;
        next_st.mb_count = st.mb_count + `CNT_W'(1);
        next_st.state = ST_IDLE;
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // stray vector data outside its slot is flagged, not consumed
    if (motion_vector_data.valid && st.state != ST_VEC) begin
      next_st.orphan = 1'b1;
    end

    // one wait state: pready rises in the second access cycle
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      if (paddr == `REG_CTRL) begin
        if (pwrite) begin
          next_st.enable = pwdata[`CTRL_ENABLE_BIT];
          next_st.unrestricted = pwdata[`CTRL_UNRES_BIT];
        end
        rd[`CTRL_ENABLE_BIT] = st.enable;
        rd[`CTRL_UNRES_BIT] = st.unrestricted;
      end else if (paddr == `REG_TIMING) begin
        if (pwrite) begin
          next_st.trb = pwdata[`TIMING_TRB_LSB +: `TR_W];
          next_st.trd = pwdata[`TIMING_TRD_LSB +: `TR_W];
        end
        rd[`TIMING_TRB_LSB +: `TR_W] = st.trb;
        rd[`TIMING_TRD_LSB +: `TR_W] = st.trd;
      end else if (paddr == `REG_STATUS) begin
        // any write clears the orphan flag; a new stray event wins
        if (pwrite && !(motion_vector_data.valid && st.state != ST_VEC)) begin
          next_st.orphan = 1'b0;
        end
        rd[`STATUS_STATE_LSB +: 4] = st.state;
        rd[`STATUS_MODE_LSB +: 2] = st.mode;
        rd[`STATUS_CBP_BIT] = st.cbp;
        rd[`STATUS_FWDVEC_BIT] = st.fwd_present;
        rd[`STATUS_ACTIVE_BIT] = active;
        rd[`STATUS_ORPHAN_BIT] = st.orphan;
      end else if (paddr == `REG_LEFT_VEC) begin
        rd[`LEFT_X_LSB +: `VEC_W] = st.left_vec.x;
        rd[`LEFT_Y_LSB +: `VEC_W] = st.left_vec.y;
        rd[`LEFT_HAS_BIT] = st.left_has;
      end else if (paddr == `REG_MB_COUNT) begin
        if (pwrite) begin
          next_st.mb_count = '0;
        end
        rd[`CNT_W-1:0] = st.mb_count;
      end else begin
        next_st.pslverr = 1'b1;
      end
      next_st.prdata = pwrite ? '0 : rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.mode <= MODE_BIDIR;
      st.report.mode <= MODE_BIDIR;
      st.cmd.mode <= MODE_BIDIR;
      st.enable <= `CTRL_ENABLE_RESET;
      st.unrestricted <= `CTRL_UNRES_RESET;
      st.trb <= `TRB_RESET;
      st.trd <= `TRD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign code_bit_ready = st.state[1];
  assign vec_data_ready = st.state[2];
  assign mode_report = st.report;
  assign mc_cmd = st.cmd;

endmodule : pb_bpart_mode_decoder

// ==== design/pb_vector_scaler.sv ====
`timescale 1ns/100ps
`include "pb_mode_cfg.svh"

// bidirectional vector scaling with the delta vector held at zero
module pb_vector_scaler (
  input wire pb_mode_pkg::vec_s p_vec,
  input wire logic [`TR_W-1:0] trb,
  input wire logic [`TR_W-1:0] trd,
  output pb_mode_pkg::vec_s fwd,
  output pb_mode_pkg::vec_s bwd
);
  import pb_mode_pkg::*;

  localparam int PW = `TR_W + `VEC_W + 2;

  // signed divide truncates toward zero, as the scaling requires
  function automatic vec_comp_t scale_comp(input vec_comp_t mv,
                                           input logic signed [`TR_W+1:0] num,
                                           input logic [`TR_W-1:0] den);
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] quo;
    logic signed [`TR_W+1:0] d;
    begin
      // a zero distance would divide by zero; treat it as one
      d = (den == '0) ? (`TR_W+2)'(1) : $signed({2'b00, den});
      prod = PW'(num) * PW'(mv);
      quo = prod / PW'(d);
      scale_comp = quo[`VEC_W-1:0];
    end
  endfunction : scale_comp

  logic signed [`TR_W+1:0] num_f;
  logic signed [`TR_W+1:0] num_b;

  assign num_f = $signed({2'b00, trb});
  assign num_b = $signed({2'b00, trb}) - $signed({2'b00, trd});

  assign fwd.x = scale_comp(p_vec.x, num_f, trd);
  assign fwd.y = scale_comp(p_vec.y, num_f, trd);
  assign bwd.x = scale_comp(p_vec.x, num_b, trd);
  assign bwd.y = scale_comp(p_vec.y, num_b, trd);

endmodule : pb_vector_scaler

// ==== include/pb_mode_cfg.svh ====
`ifndef PB_MODE_CFG_SVH
`define PB_MODE_CFG_SVH

// vector components are half-pel units
`define VEC_W 7
`define VEC_NARROW_W 6
`define TR_W 8
`define CNT_W 16
`define ADDR_W 8
`define DATA_W 32
`define ONES_W 3

// register byte addresses
`define REG_CTRL 8'h00
`define REG_TIMING 8'h04
`define REG_STATUS 8'h08
`define REG_LEFT_VEC 8'h0c
`define REG_MB_COUNT 8'h10

// field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_UNRES_BIT 1
`define TIMING_TRB_LSB 0
`define TIMING_TRD_LSB 8
`define STATUS_STATE_LSB 0
`define STATUS_MODE_LSB 4
`define STATUS_CBP_BIT 6
`define STATUS_FWDVEC_BIT 7
`define STATUS_ACTIVE_BIT 8
`define STATUS_ORPHAN_BIT 9
`define LEFT_X_LSB 0
`define LEFT_Y_LSB 8
`define LEFT_HAS_BIT 16

// reset values
`define CTRL_ENABLE_RESET 1'b0
`define CTRL_UNRES_RESET 1'b0
`define TRB_RESET 8'h01
`define TRD_RESET 8'h02

// ones already seen when the fifth code bit decides alone
`define ONES_LAST 3'h4
// code index of the all-ones code
`define CODE_IDX_LAST 3'h5

`endif

// ==== include/pb_mode_pkg.sv ====
`include "pb_mode_cfg.svh"

package pb_mode_pkg;

  typedef logic signed [`VEC_W-1:0] vec_comp_t;

  typedef struct packed {
    vec_comp_t x;
    vec_comp_t y;
  } vec_s;

  typedef enum logic [1:0] {
    MODE_BIDIR = 2'h0,
    MODE_FWD = 2'h1,
    MODE_BWD = 2'h2
  } bpart_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CODE = 4'h2,
    ST_VEC = 4'h4,
    ST_ISSUE = 4'h8
  } dec_state_e;

  // macroblock context from the parser, start is a one-cycle pulse
  typedef struct packed {
    logic start;
    logic left_edge;
    logic p_intra;
    vec_s p_vec;
  } mb_ctx_s;

  typedef struct packed {
    logic valid;
    vec_s diff;
  } vec_data_s;

  typedef struct packed {
    logic valid;
    bpart_mode_e mode;
    logic block_pattern_present;
    logic forward_vector_present;
    logic p_vec_data_required;
  } mode_report_s;

  typedef struct packed {
    logic valid;
    bpart_mode_e mode;
    logic use_prev_ref;
    logic use_cur_p;
    logic unrestricted;
    vec_s fwd;
    vec_s bwd;
  } mc_cmd_s;

endpackage : pb_mode_pkg

// ==== verification/pb_bpart_mode_decoder_tb_top.sv ====
`timescale 1ns/100ps
module pb_bpart_mode_decoder_tb_top;
  import pb_mode_pkg::*;
  localparam int TRB = 3;
  localparam int TRD = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_type;
  logic code_bit_valid, code_bit, code_bit_ready, vec_data_ready, lhas, unres;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  mb_ctx_s mb_ctx;
  vec_data_s vdata;
  mode_report_s rep;
  mc_cmd_s cmd;
  vec_s lvec;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 57108;
  logic [32:0] qa[$];
  mode_report_s qr[$];
  mc_cmd_s qc[$];
  pb_bpart_mode_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extended_picture_type(ext_type), .mb_ctx(mb_ctx),
    .code_bit_valid(code_bit_valid), .code_bit(code_bit), .code_bit_ready(code_bit_ready),
    .motion_vector_data(vdata), .vec_data_ready(vec_data_ready), .mode_report(rep),
    .mc_cmd(cmd));
  pb_parser_model i_parser (.pclk(pclk), .code_bit_ready(code_bit_ready),
    .vec_data_ready(vec_data_ready), .mc_valid(cmd.valid), .mb_ctx(mb_ctx),
    .code_bit_valid(code_bit_valid), .code_bit(code_bit), .motion_vector_data(vdata));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic final_report();
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic ok, input string what);
    checks_done++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s mismatch", $time, what);
    end
  endtask : cmp
  task automatic cmp_reg(input logic [32:0] g, input logic [32:0] e);
    cmp(g === e, "register");
  endtask : cmp_reg
  task automatic cmp_rep(input mode_report_s g, input mode_report_s e);
    cmp(g === e, "mode report");
  endtask : cmp_rep
  task automatic cmp_cmd(input mc_cmd_s g, input mc_cmd_s e);
    cmp(g === e, "mc command");
  endtask : cmp_cmd
  always @(posedge pclk) begin
    if (pready) cmp_reg({pslverr, prdata}, qa.pop_front());
    if (rep.valid) cmp_rep(rep, qr.pop_front());
    if (cmd.valid) cmp_cmd(cmd, qc.pop_front());
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      final_report();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    qa.push_back({ee, ed});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mb(input int idx);
    logic le, pi;
    vec_s pv, d, f;
    mc_cmd_s c;
    bpart_mode_e bm;
    le = 1'($random(seed));
    pi = 1'($random(seed));
    pv = {7'($random(seed) % 32), 7'($random(seed) % 32)};
    d = {7'($random(seed) % 32), 7'($random(seed) % 32)};
    bm = idx < 2 ? MODE_BIDIR : (idx < 4 ? MODE_FWD : MODE_BWD);
    qr.push_back({1'b1, bm, idx % 2 == 1, bm == MODE_FWD, bm == MODE_BIDIR || !pi});
    f = (!le && lhas) ? lvec : '0;
    f.x = f.x + d.x;
    f.y = f.y + d.y;
    if (!unres) f = {f.x[5], f.x[5:0], f.y[5], f.y[5:0]};
    c = '0;
    c.valid = 1'b1;
    c.mode = bm;
    c.unrestricted = unres;
    c.use_prev_ref = bm != MODE_BWD;
    c.use_cur_p = bm != MODE_FWD;
    if (bm == MODE_FWD) c.fwd = f;
    if (bm == MODE_BIDIR) begin
      c.fwd = {7'(TRB * int'(pv.x) / TRD), 7'(TRB * int'(pv.y) / TRD)};
      c.bwd = {7'((TRB - TRD) * int'(pv.x) / TRD), 7'((TRB - TRD) * int'(pv.y) / TRD)};
    end
    qc.push_back(c);
    lhas = bm == MODE_FWD;
    if (lhas) lvec = f;
    i_parser.send(idx, le, pi, pv, d, {$random(seed)} % 3);
  endtask : mb
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_type = 1'b0;
    lhas = 1'b0;
    lvec = '0;
    unres = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0, 32'h0, 0);
    apb(0, 8'h04, 0, 32'h0201, 0);
    apb(0, 8'h10, 0, 32'h0, 0);
    apb(1, 8'h14, 32'hffffffff, 32'h0, 1);
    apb(0, 8'h14, 0, 32'h0, 1);
    apb(1, 8'h04, 32'h0403, 32'h0, 0);
    apb(0, 8'h04, 0, 32'h0403, 0);
    apb(1, 8'h00, 32'h1, 32'h0, 0);
    i_parser.poke();
    apb(0, 8'h08, 0, 32'h1, 0);
    @(posedge pclk);
    ext_type <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      if (r == 1) begin
        unres = 1'b1;
        apb(1, 8'h00, 32'h3, 32'h0, 0);
      end
      for (int k = 0; k < 6; k++) mb(k);
    end
    mb(2);
    apb(0, 8'h10, 0, 32'd13, 0);
    apb(1, 8'h0c, 32'h0, 32'h0, 0);
    apb(0, 8'h0c, 0, {15'h0, 1'b1, 1'b0, lvec.y, 1'b0, lvec.x}, 0);
    i_parser.stray();
    apb(0, 8'h08, 0, 32'h391, 0);
    apb(1, 8'h08, 32'h0, 32'h0, 0);
    apb(0, 8'h08, 0, 32'h191, 0);
    apb(1, 8'h10, 32'h0, 32'h0, 0);
    apb(0, 8'h10, 0, 32'h0, 0);
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule : pb_bpart_mode_decoder_tb_top

// ==== verification/pb_mode_checker_asserts.sv ====
`timescale 1ns/100ps
module pb_mode_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire pb_mode_pkg::mb_ctx_s mb_ctx,
  input wire logic code_bit_ready,
  input wire pb_mode_pkg::vec_data_s motion_vector_data,
  input wire logic vec_data_ready,
  input wire pb_mode_pkg::mode_report_s mode_report,
  input wire pb_mode_pkg::mc_cmd_s mc_cmd
);
  import pb_mode_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb access not answered in two cycles");
  chk_err_pulse: assert property (pslverr |-> pready)
    else $error("error response without ready");
  chk_start_code: assert property ($rose(code_bit_ready) |-> $past(mb_ctx.start))
    else $error("code wait without start");
  chk_report_cmd: assert property (mode_report.valid && mode_report.mode != MODE_FWD
    |=> mc_cmd.valid) else $error("no command after report");
  chk_vec_wait: assert property ($rose(vec_data_ready) |-> mode_report.valid
    && mode_report.mode == MODE_FWD) else $error("vector wait outside forward mode");
  chk_fwd_cmd: assert property (vec_data_ready && motion_vector_data.valid
    |=> mc_cmd.valid && mc_cmd.mode == MODE_FWD) else $error("no forward command");
  chk_fwd_flag: assert property (mode_report.valid |->
    mode_report.forward_vector_present == (mode_report.mode == MODE_FWD))
    else $error("forward vector flag wrong");
  chk_bidir_vecdata: assert property (mode_report.valid && mode_report.mode == MODE_BIDIR
    |-> mode_report.p_vec_data_required) else $error("bidir without vector data");
  chk_bidir_refs: assert property (mc_cmd.valid && mc_cmd.mode == MODE_BIDIR
    |-> mc_cmd.use_prev_ref && mc_cmd.use_cur_p) else $error("bidir references wrong");
  chk_bwd_cmd: assert property (mc_cmd.valid && mc_cmd.mode == MODE_BWD |->
    mc_cmd.use_cur_p && !mc_cmd.use_prev_ref && mc_cmd.fwd == '0 && mc_cmd.bwd == '0)
    else $error("backward command wrong");
endmodule : pb_mode_checker

bind pb_bpart_mode_decoder pb_mode_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .mb_ctx(mb_ctx),
  .code_bit_ready(code_bit_ready), .motion_vector_data(motion_vector_data),
  .vec_data_ready(vec_data_ready), .mode_report(mode_report), .mc_cmd(mc_cmd));

// ==== verification/pb_parser_model.sv ====
`timescale 1ns/100ps
module pb_parser_model (
  input wire logic pclk,
  input wire logic code_bit_ready,
  input wire logic vec_data_ready,
  input wire logic mc_valid,
  output pb_mode_pkg::mb_ctx_s mb_ctx,
  output logic code_bit_valid,
  output logic code_bit,
  output pb_mode_pkg::vec_data_s motion_vector_data
);
  import pb_mode_pkg::*;
  initial begin
    mb_ctx = '0;
    code_bit_valid = 1'b0;
    code_bit = 1'b0;
    motion_vector_data = '0;
  end
  // start pulse only, for a picture that must leave the block idle
  task automatic poke();
    @(posedge pclk);
    mb_ctx.start <= 1'b1;
    @(posedge pclk);
    mb_ctx.start <= 1'b0;
  endtask : poke
  task automatic send(input int idx, input logic le, input logic pi, input vec_s pv,
                      input vec_s d, input int gap);
    int n;
    n = (idx < 4) ? idx + 1 : 5;
    @(posedge pclk);
    mb_ctx <= {1'b1, le, pi, pv};
    @(posedge pclk);
    mb_ctx.start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      // released line toggles so a stale bit never looks valid
      if (gap > 0) begin
        code_bit_valid <= 1'b0;
        code_bit <= ~code_bit;
        repeat (gap) @(posedge pclk);
      end
      code_bit_valid <= 1'b1;
      code_bit <= (i < n - 1) || (idx == 5);
      do @(posedge pclk); while (!code_bit_ready);
    end
    code_bit_valid <= 1'b0;
    code_bit <= ~code_bit;
    if (idx == 2 || idx == 3) begin
      repeat (gap) @(posedge pclk);
      motion_vector_data <= {1'b1, d};
      do @(posedge pclk); while (!vec_data_ready);
      motion_vector_data <= {1'b0, ~d};
    end
    do @(posedge pclk); while (!mc_valid);
  endtask : send
  // vector data outside its slot, only to raise the orphan flag
  task automatic stray();
    @(posedge pclk);
    motion_vector_data.valid <= 1'b1;
    @(posedge pclk);
    motion_vector_data.valid <= 1'b0;
  endtask : stray
endmodule : pb_parser_model
